// File: core/sysinfo_regs.v
// system info register bank: identity, revisions, label, tick counters, restart and stall
`timescale 1ns/10ps
`include "sysinfo_map.vh"
module sysinfo_regs #(
	parameter [31:0] DEVICE_KIND = 32'h3F800000,
	parameter [31:0] BOARD_REV = 32'h3F800000,
	parameter [31:0] MAIN_CODE_REV = 32'h3F800000,
	parameter [31:0] LOADER_REV = 32'h3F800000,
	parameter [31:0] RADIO_CODE_REV = 32'h00000000,
	parameter [63:0] WIRED_ADDR = 64'h0000001122334455,
	parameter [63:0] RADIO_ADDR = 64'h0000001122334466,
	parameter [31:0] SERIAL = 32'h00000001,
	// arbitrary neutral unlock key
	parameter [15:0] RESTART_KEY = 16'hA55A,
	parameter SLOW_TICK_CYCLES = `CYCLES_PER_SLOW_TICK,
	parameter RESTART_UNIT_CYCLES = `CYCLES_PER_RESTART_UNIT,
	parameter US_CYCLES = `CYCLES_PER_US
) (
	input wire clk,
	input wire reset_n,
	input wire req,
	input wire req_write,
	input wire [15:0] req_addr,
	input wire [31:0] req_wdata,
	output wire req_ready,
	output reg rsp_valid,
	output reg [31:0] rsp_rdata,
	output reg rsp_error,
	input wire option_hires,
	input wire option_radio,
	input wire option_calendar,
	output reg restart,
	output reg [`LABEL_BITS-1:0] announced_label
);
	// one-hot access states
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_STALL = 2'b10;

	reg rst_meta;
	reg rst_n;
	reg [1:0] state;
	reg [31:0] fast_tick;
	reg fast_phase;
	reg [31:0] slow_tick;
	reg [31:0] stall_value;
	reg [16:0] us_left;
	reg restart_pending;
	reg [15:0] restart_left;
	reg [31:0] label_mem [0:`LABEL_WORDS-1];
	reg [31:0] next_rdata;
	reg next_error;
	reg label_hit;
	reg [15:0] label_off;
	reg [3:0] label_idx;
	wire slow_pulse;
	wire unit_pulse;
	wire us_pulse;
	wire take;
	integer i;

	// reset is released through two flops
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// pacing for the slow tick, the restart unit and the stall microsecond
	tick_divider #(.WIDTH(24), .DIVIDE(SLOW_TICK_CYCLES)) u_slow (
		.clk(clk),
		.rst_n(rst_n),
		.run(1'b1),
		.tick(slow_pulse)
	);

	tick_divider #(.WIDTH(24), .DIVIDE(RESTART_UNIT_CYCLES)) u_unit (
		.clk(clk),
		.rst_n(rst_n),
		.run(restart_pending),
		.tick(unit_pulse)
	);

	tick_divider #(.WIDTH(8), .DIVIDE(US_CYCLES)) u_us (
		.clk(clk),
		.rst_n(rst_n),
		.run(state == ST_STALL),
		.tick(us_pulse)
	);

	// nothing is taken while a stall holds the bank
	assign req_ready = (state == ST_IDLE);
	assign take = req && req_ready;

	// free-running tick counters
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fast_tick <= 32'h00000000;
			fast_phase <= 1'b0;
			slow_tick <= 32'h00000000;
		end
		else
		begin
			fast_phase <= ~fast_phase;
			if (fast_phase)
				fast_tick <= fast_tick + 32'h00000001;
			if (slow_pulse)
				slow_tick <= slow_tick + 32'h00000001;
		end
	end

	// label window: 13 words at even addresses
	always @*
	begin
		label_off = req_addr - `ADDR_UNIT_LABEL;
		label_hit = (req_addr >= `ADDR_UNIT_LABEL) && !label_off[0]
			&& (label_off[15:1] < `LABEL_WORDS);
		label_idx = label_off[4:1];
	end

	// read data and error decode
	always @*
	begin
		next_rdata = 32'h00000000;
		next_error = 1'b0;
		if (label_hit)
			next_rdata = label_mem[label_idx];
		else
		begin
			case (req_addr)
			`ADDR_DEVICE_KIND_CODE: next_rdata = DEVICE_KIND;
			`ADDR_BOARD_REVISION: next_rdata = BOARD_REV;
			`ADDR_MAIN_CODE_REVISION: next_rdata = MAIN_CODE_REV;
			`ADDR_LOADER_REVISION: next_rdata = LOADER_REV;
			`ADDR_RADIO_CODE_REVISION: next_rdata = option_radio ? RADIO_CODE_REV : 32'h00000000;
			`ADDR_OPTION_PRESENCE_MASK:
			begin
				next_rdata[`OPT_HIRES_BIT] = option_hires;
				next_rdata[`OPT_RADIO_BIT] = option_radio;
				next_rdata[`OPT_CALENDAR_BIT] = option_calendar;
			end
			`ADDR_WIRED_STATION_ADDR: next_rdata = WIRED_ADDR[63:32];
			`ADDR_WIRED_STATION_ADDR + 16'h0002: next_rdata = WIRED_ADDR[31:0];
			`ADDR_RADIO_STATION_ADDR: next_rdata = RADIO_ADDR[63:32];
			`ADDR_RADIO_STATION_ADDR + 16'h0002: next_rdata = RADIO_ADDR[31:0];
			`ADDR_UNIT_SERIAL: next_rdata = SERIAL;
			`ADDR_FAST_TICK_COUNTER: next_rdata = fast_tick;
			`ADDR_SLOW_TICK_COUNTER: next_rdata = slow_tick;
			`ADDR_STALL_DELAY_US: next_rdata = stall_value;
			default: next_error = 1'b1;
			endcase
			// only the stall and restart registers accept writes here
			if (req_write && req_addr != `ADDR_STALL_DELAY_US
				&& req_addr != `ADDR_RESTART_REQUEST)
				next_error = 1'b1;
			if (!req_write && req_addr == `ADDR_RESTART_REQUEST)
				next_error = 1'b1;
			if (req_write && req_addr == `ADDR_RESTART_REQUEST)
				next_error = 1'b0;
		end
	end

	// register access, stall sequencing and restart countdown
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			rsp_valid <= 1'b0;
			rsp_rdata <= 32'h00000000;
			rsp_error <= 1'b0;
			stall_value <= `STALL_RESET;
			us_left <= 17'h00000;
			restart_pending <= 1'b0;
			restart_left <= 16'h0000;
			restart <= 1'b0;
			for (i = 0; i < `LABEL_WORDS; i = i + 1)
				label_mem[i] <= 32'h00000000;
		end
		else
		begin
			rsp_valid <= 1'b0;
			restart <= 1'b0;
			case (state)
			// one access accepted per cycle while idle
			ST_IDLE:
			begin
				if (take)
				begin
					rsp_rdata <= req_write ? 32'h00000000 : next_rdata;
					rsp_error <= next_error;
					rsp_valid <= 1'b1;
					if (req_write && label_hit)
					begin
						// the 13th word holds only the 49th character
						if (label_idx == `LABEL_WORDS - 1)
							label_mem[label_idx] <= {req_wdata[31:24], 24'h000000};
						else
							label_mem[label_idx] <= req_wdata;
					end
					if (req_write && req_addr == `ADDR_STALL_DELAY_US)
					begin
						if (req_wdata > `STALL_MAX_US)
							rsp_error <= 1'b1;
						else
						begin
							stall_value <= req_wdata;
							if (req_wdata != 32'h00000000)
							begin
								rsp_valid <= 1'b0;
								us_left <= req_wdata[16:0];
								state <= ST_STALL;
							end
						end
					end
					if (req_write && req_addr == `ADDR_RESTART_REQUEST
						&& req_wdata[31:16] == RESTART_KEY)
					begin
						if (req_wdata[15:0] == 16'h0000)
						begin
							restart <= 1'b1;
							restart_pending <= 1'b0;
						end
						else
						begin
							restart_pending <= 1'b1;
							restart_left <= req_wdata[15:0];
						end
					end
				end
			end
			// stall counts down one microsecond at a time
			ST_STALL:
			begin
				if (us_pulse)
				begin
					us_left <= us_left - 17'h00001;
					if (us_left == 17'h00001)
					begin
						rsp_valid <= 1'b1;
						rsp_rdata <= 32'h00000000;
						rsp_error <= 1'b0;
						state <= ST_IDLE;
					end
				end
			end
			default: state <= ST_IDLE;
			endcase
			// restart countdown in delay units
			if (restart_pending && unit_pulse)
			begin
				restart_left <= restart_left - 16'h0001;
				if (restart_left == 16'h0001)
				begin
					restart <= 1'b1;
					restart_pending <= 1'b0;
				end
			end
		end
	end

	// the announced name follows the label only across a restart
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			announced_label <= {`LABEL_BITS{1'b0}};
		else if (restart)
		begin
			for (i = 0; i < `LABEL_WORDS - 1; i = i + 1)
				announced_label[`LABEL_BITS-1-32*i -: 32] <= label_mem[i];
			announced_label[7:0] <= label_mem[`LABEL_WORDS-1][31:24];
		end
	end
endmodule // sysinfo_regs

// File: inc/sysinfo_map.vh
// address map, field positions, reset values and timing counts of the system info register bank
`ifndef SYSINFO_MAP_VH
`define SYSINFO_MAP_VH

`define ADDR_DEVICE_KIND_CODE 16'hEA60
`define ADDR_BOARD_REVISION 16'hEA62
`define ADDR_MAIN_CODE_REVISION 16'hEA64
`define ADDR_LOADER_REVISION 16'hEA66
`define ADDR_RADIO_CODE_REVISION 16'hEA68
`define ADDR_OPTION_PRESENCE_MASK 16'hEA6A
`define ADDR_WIRED_STATION_ADDR 16'hEA74
`define ADDR_RADIO_STATION_ADDR 16'hEA78
`define ADDR_UNIT_SERIAL 16'hEA7C
`define ADDR_UNIT_LABEL 16'hEC54
`define ADDR_FAST_TICK_COUNTER 16'hF050
`define ADDR_SLOW_TICK_COUNTER 16'hF052
`define ADDR_STALL_DELAY_US 16'hF096
`define ADDR_RESTART_REQUEST 16'hF22E

`define OPT_HIRES_BIT 0
`define OPT_RADIO_BIT 1
`define OPT_CALENDAR_BIT 2

`define LABEL_CHARS 49
`define LABEL_WORDS 13
`define LABEL_BITS 392

`define RESTART_KEY_WIDTH 16
`define STALL_MAX_US 32'h000186A0
`define STALL_RESET 32'h00000000

`define CLK_HZ 200000000
`define MICROSECOND_NS 1000
`define CLK_PERIOD_NS 5
`define CYCLES_PER_US (`MICROSECOND_NS / `CLK_PERIOD_NS)
`define SLOW_TICK_HZ 20
`define CYCLES_PER_SLOW_TICK (`CLK_HZ / `SLOW_TICK_HZ)
`define RESTART_UNIT_MS 50
`define CYCLES_PER_RESTART_UNIT (`CLK_HZ / 1000 * `RESTART_UNIT_MS)

`endif

// File: core/tick_divider.v
// periodic tick generator counting core clock cycles while enabled
`timescale 1ns/10ps
module tick_divider #(
	parameter WIDTH = 24,
	parameter DIVIDE = 200
) (
	input wire clk,
	input wire rst_n,
	input wire run,
	output reg tick
);
	localparam integer LAST_INT = DIVIDE - 1;
	localparam [WIDTH-1:0] LAST = LAST_INT[WIDTH-1:0];
	reg [WIDTH-1:0] count;

	// count restarts from zero whenever run drops, so each period starts cleanly
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count <= {WIDTH{1'b0}};
			tick <= 1'b0;
		end
		else if (!run)
		begin
			count <= {WIDTH{1'b0}};
			tick <= 1'b0;
		end
		else if (count == LAST)
		begin
			count <= {WIDTH{1'b0}};
			tick <= 1'b1;
		end
		else
		begin
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
			tick <= 1'b0;
		end
	end
endmodule // tick_divider

// File: verification/sysinfo_regs_sva.sv
// port assertions for the system info register bank
`timescale 1ns/10ps
`include "sysinfo_map.vh"
module sysinfo_regs_sva #(
	parameter [15:0] RESTART_KEY = 16'hA55A
) (
	input wire clk,
	input wire reset_n,
	input wire req,
	input wire req_write,
	input wire [15:0] req_addr,
	input wire [31:0] req_wdata,
	input wire req_ready,
	input wire rsp_valid,
	input wire [31:0] rsp_rdata,
	input wire rsp_error,
	input wire option_hires,
	input wire option_radio,
	input wire option_calendar,
	input wire restart,
	input wire [`LABEL_BITS-1:0] announced_label
);
default clocking @(posedge clk); endclocking
default disable iff (!reset_n);
wire tk = req && req_ready;
wire tw = tk && req_write;
wire st = tw && req_addr == `ADDR_STALL_DELAY_US;
property p_read; tk && !req_write |=> rsp_valid; endproperty
a_read: assert property (p_read) else $error("read not answered");
property p_ro; tw && req_addr == `ADDR_DEVICE_KIND_CODE |=> rsp_valid && rsp_error; endproperty
a_ro: assert property (p_ro) else $error("read-only write accepted");
property p_mask; tk && !req_write && req_addr == `ADDR_OPTION_PRESENCE_MASK |=>
	rsp_rdata[2:0] == {$past(option_calendar), $past(option_radio), $past(option_hires)};
endproperty
a_mask: assert property (p_mask) else $error("option mask wrong");
property p_now; tw && req_addr == `ADDR_RESTART_REQUEST && req_wdata == {RESTART_KEY, 16'h0000}
	|=> restart; endproperty
a_now: assert property (p_now) else $error("no immediate restart");
property p_pulse; restart |=> !restart; endproperty
a_pulse: assert property (p_pulse) else $error("restart pulse too long");
property p_name; $changed(announced_label) |-> $past(restart); endproperty
a_name: assert property (p_name) else $error("name changed without restart");
property p_busy; st && req_wdata != 0 && req_wdata <= `STALL_MAX_US |=> !req_ready [*3]; endproperty
a_busy: assert property (p_busy) else $error("ready during stall");
property p_big; st && req_wdata > `STALL_MAX_US |=> rsp_valid && rsp_error && req_ready; endproperty
a_big: assert property (p_big) else $error("oversize stall not refused");
property p_one; st && req_wdata == 1 |=> !rsp_valid [*5] ##1 rsp_valid; endproperty
a_one: assert property (p_one) else $error("stall length wrong");
endmodule // sysinfo_regs_sva
bind sysinfo_regs sysinfo_regs_sva #(.RESTART_KEY(RESTART_KEY)) i_sysinfo_regs_sva (.clk(clk),
	.reset_n(reset_n), .req(req), .req_write(req_write), .req_addr(req_addr),
	.req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
	.rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .option_hires(option_hires),
	.option_radio(option_radio), .option_calendar(option_calendar), .restart(restart),
	.announced_label(announced_label));

// File: verification/testbench.sv
// self-checking bench for the system info register bank
`timescale 1ns/10ps
`include "sysinfo_map.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
reg clk = 0, reset_n = 0, req = 0, req_write = 0;
reg [15:0] req_addr = 0;
reg [31:0] req_wdata = 0;
reg option_hires = 0, option_radio = 0, option_calendar = 0;
wire req_ready, rsp_valid, rsp_error, restart;
wire [31:0] rsp_rdata;
wire [`LABEL_BITS-1:0] announced_label;
integer failures = 0, n_checks = 0, restarts = 0, i, t0, g;
reg [33:0] q[$];
reg [31:0] rq[$];
reg [33:0] e;
reg [31:0] w0, v;
always #2.5 clk = ~clk;
sysinfo_regs #(.SLOW_TICK_CYCLES(20), .RESTART_UNIT_CYCLES(10), .US_CYCLES(4)) i_sysinfo_regs (
	.clk(clk), .reset_n(reset_n), .req(req), .req_write(req_write), .req_addr(req_addr),
	.req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
	.rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .option_hires(option_hires),
	.option_radio(option_radio), .option_calendar(option_calendar), .restart(restart),
	.announced_label(announced_label));
always @(posedge clk)
begin
	if (restart === 1'b1)
		restarts++;
	if (rsp_valid === 1'b1)
	begin
		rq.push_back(rsp_rdata);
		if (q.size() == 0) `CHK("extra", 1'b0, 1'b1) else
		begin
			e = q.pop_front();
			`CHK("err", e[32], rsp_error)
			if (e[33]) `CHK("data", e[31:0], rsp_rdata)
		end
	end
end
task acc(input reg w, input reg [15:0] a, input reg [31:0] d, input reg ck, input reg er,
	input reg [31:0] x);
begin
	q.push_back({ck, er, x});
	@(posedge clk);
	req <= 1;
	req_write <= w;
	req_addr <= a;
	req_wdata <= d;
	@(posedge clk);
	while (req_ready !== 1'b1) @(posedge clk);
	req <= 0;
	t0 = $time;
end
endtask
task rd(input reg [15:0] a, input reg [31:0] x);
	acc(0, a, 0, 1, 0, x);
endtask
task drain;
begin
	while (q.size() != 0) @(posedge clk);
	repeat (3) @(posedge clk);
end
endtask
task complete_run;
begin
	$display("checks %0d failures %0d", n_checks, failures);
	if (failures == 0 && n_checks > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
end
endtask
initial
begin
	v = $urandom(32'h91B4D104);
	repeat (4) @(posedge clk);
	reset_n <= 1;
	repeat (3) @(posedge clk);
	for (i = 0; i < 4; i++) rd(16'hEA60 + 2 * i, 32'h3F800000);
	rd(`ADDR_RADIO_CODE_REVISION, 32'h00000000);
	rd(`ADDR_WIRED_STATION_ADDR + 2, 32'h22334455);
	rd(`ADDR_RADIO_STATION_ADDR, 32'h00000011);
	rd(`ADDR_RADIO_STATION_ADDR + 2, 32'h22334466);
	rd(`ADDR_UNIT_SERIAL, 32'h00000001);
	for (i = 0; i < 4; i++)
	begin
		v = $urandom;
		{option_calendar, option_radio, option_hires} <= v[2:0];
		rd(`ADDR_OPTION_PRESENCE_MASK, {29'h0, v[2:0]});
	end
	acc(1, `ADDR_DEVICE_KIND_CODE, v, 0, 1, 0);
	acc(0, `ADDR_RESTART_REQUEST, 0, 0, 1, 0);
	w0 = $urandom;
	v = $urandom;
	acc(1, `ADDR_UNIT_LABEL, w0, 0, 0, 0);
	acc(1, `ADDR_UNIT_LABEL + 24, v, 0, 0, 0);
	rd(`ADDR_UNIT_LABEL, w0);
	rd(`ADDR_UNIT_LABEL + 24, v & 32'hFF000000);
	acc(1, `ADDR_RESTART_REQUEST, 32'h12340000, 0, 0, 0);
	drain;
	repeat (20) @(posedge clk);
	`CHK("name", {`LABEL_BITS{1'b0}}, announced_label)
	`CHK("restarts", 0, restarts)
	acc(1, `ADDR_RESTART_REQUEST, 32'hA55A0000, 0, 0, 0);
	drain;
	`CHK("restarts", 1, restarts)
	`CHK("name", w0, announced_label[391:360])
	acc(1, `ADDR_RESTART_REQUEST, 32'hA55A0003, 0, 0, 0);
	repeat (25) @(posedge clk);
	`CHK("restarts", 1, restarts)
	repeat (10) @(posedge clk);
	`CHK("restarts", 2, restarts)
	for (i = 0; i < 2; i++)
	begin
		drain;
		rq.delete();
		acc(0, 16'hF050 + 2 * i, 0, 0, 0, 0);
		repeat (18) @(posedge clk);
		acc(0, 16'hF050 + 2 * i, 0, 0, 0, 0);
		drain;
		`CHK("tick", (i ? 32'd1 : 32'd10), rq[1] - rq[0])
	end
	acc(1, `ADDR_STALL_DELAY_US, 3, 0, 0, 0);
	g = t0;
	rd(`ADDR_STALL_DELAY_US, 3);
	`CHK("gap", 1'b1, ((t0 - g) / 5 >= 13 && (t0 - g) / 5 <= 14))
	acc(1, `ADDR_STALL_DELAY_US, 32'd100001, 0, 1, 0);
	rd(`ADDR_STALL_DELAY_US, 3);
	acc(1, `ADDR_STALL_DELAY_US, 1, 0, 0, 0);
	acc(1, `ADDR_STALL_DELAY_US, 0, 0, 0, 0);
	drain;
	complete_run;
end
initial
begin
	#100000;
	failures++;
	complete_run;
end
endmodule // testbench
